// >>> hdl/fgr_ctrl.sv
// Controller end: issues mode set and refresh commands at the mode's pace
module fgr_ctrl (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Command bus
    fgr_cmd_if.ctrl         cmd,
    // Mode change request
    input  wire logic       mode_req_valid,
    input  wire logic [2:0] mode_req,
    input  wire logic       temperature_scaled_refresh,
    // Refresh steering
    input  wire logic [1:0] temp_band,
    input  wire logic       fast_refresh_pref,
    // Status
    output logic            mode_ack,
    output logic            mode_reject,
    output logic [2:0]      fine_refresh_rate_mode,
    output logic            refresh_issued,
    output logic [1:0]      refresh_kind,
    output logic            refresh_busy
);

    typedef enum logic [1:0] {
        FGR_IDLE,
        FGR_RFC_WAIT,
        FGR_MRS_WAIT
    } fgr_ctrl_state_t;

    typedef struct packed {
        fgr_ctrl_state_t           state;
        logic [2:0]                mode;
        logic                      pend;
        logic [2:0]                pend_mode;
        logic [fgr_pkg::CNT_W-1:0] refi_cnt;
        logic [fgr_pkg::CNT_W-1:0] wait_cnt;
        logic                      busy;
        logic                      ack;
        logic                      rej;
        logic                      issued;
        fgr_pkg::fgr_kind_t        kind;
        logic                      cs_n;
        logic                      ras_n;
        logic                      cas_n;
        logic                      we_n;
        logic                      bg0;
        logic [1:0]                ba;
        logic [13:0]               addr;
    } fgr_ctrl_st_t;

    fgr_ctrl_st_t       st;
    fgr_ctrl_st_t       next_st;
    fgr_pkg::fgr_kind_t sel_kind;
    logic [2:0]         rate_shift;
    logic [fgr_pkg::CNT_W-1:0] refi_load;
    logic               mode_ok;

    ////////////////////////////////////////////////////////////////////////
    // Kind of next refresh from programmed mode
    always_comb begin
        case (st.mode)
            fgr_pkg::MODE_FIXED_2X: sel_kind = fgr_pkg::FGR_KIND_2X;
            fgr_pkg::MODE_FIXED_4X: sel_kind = fgr_pkg::FGR_KIND_4X;
            fgr_pkg::MODE_DYN_1X2X: sel_kind = fast_refresh_pref ? fgr_pkg::FGR_KIND_2X
                                                                 : fgr_pkg::FGR_KIND_1X;
            fgr_pkg::MODE_DYN_1X4X: sel_kind = fast_refresh_pref ? fgr_pkg::FGR_KIND_4X
                                                                 : fgr_pkg::FGR_KIND_1X;
            default:                sel_kind = fgr_pkg::FGR_KIND_1X;
        endcase
    end

    // Interval for that kind and temperature band
    always_comb begin
        rate_shift = {1'b0, sel_kind} + {1'b0, temp_band};
        refi_load  = fgr_pkg::CNT_W'(fgr_pkg::REFI_BASE_CYC) >> rate_shift;
    end

    // Accept only documented codes; scaling allows only fixed 1x
    always_comb begin
        case (mode_req)
            fgr_pkg::MODE_FIXED_1X: mode_ok = 1'b1;
            fgr_pkg::MODE_FIXED_2X,
            fgr_pkg::MODE_FIXED_4X,
            fgr_pkg::MODE_DYN_1X2X,
            fgr_pkg::MODE_DYN_1X4X: mode_ok = !temperature_scaled_refresh;
            default:                mode_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st        = st;
        next_st.ack    = 1'b0;
        next_st.rej    = 1'b0;
        next_st.issued = 1'b0;
        // Bus returns to deselect after each one-cycle command
        next_st.cs_n   = 1'b1;
        next_st.ras_n  = 1'b1;
        next_st.cas_n  = 1'b1;
        next_st.we_n   = 1'b1;
        next_st.bg0    = 1'b0;
        next_st.ba     = 2'h0;
        next_st.addr   = 14'h0000;
        if (st.refi_cnt != fgr_pkg::CNT_ZERO) begin
            next_st.refi_cnt = st.refi_cnt - 1'b1;
        end
        if (mode_req_valid && !st.pend) begin
            if (mode_ok) begin
                next_st.pend      = 1'b1;
                next_st.pend_mode = mode_req;
            end else begin
                next_st.rej = 1'b1;
            end
        end
        case (st.state)
            FGR_IDLE: begin
                if (st.refi_cnt == fgr_pkg::CNT_ZERO) begin
                    // Refresh due: one cycle of refresh encoding
                    next_st.cs_n     = 1'b0;
                    next_st.ras_n    = 1'b0;
                    next_st.cas_n    = 1'b0;
                    next_st.we_n     = 1'b1;
                    next_st.bg0      = (sel_kind != fgr_pkg::FGR_KIND_1X);
                    next_st.kind     = sel_kind;
                    next_st.issued   = 1'b1;
                    next_st.refi_cnt = refi_load;
                    next_st.wait_cnt = fgr_pkg::fgr_rfc_cyc(sel_kind);
                    next_st.state    = FGR_RFC_WAIT;
                    next_st.busy     = 1'b1;
                end else if (st.pend) begin
                    // Mode set goes out before any refresh relying on it
                    next_st.cs_n                          = 1'b0;
                    next_st.ras_n                         = 1'b0;
                    next_st.cas_n                         = 1'b0;
                    next_st.we_n                          = 1'b0;
                    next_st.ba                            = fgr_pkg::MR3_BANK;
                    next_st.addr[fgr_pkg::MODE_LSB +: 3]  = st.pend_mode;
                    next_st.mode                          = st.pend_mode;
                    next_st.pend                          = 1'b0;
                    next_st.ack                           = 1'b1;
                    next_st.refi_cnt                      = fgr_pkg::CNT_ZERO;
                    next_st.wait_cnt = fgr_pkg::CNT_W'(fgr_pkg::MRS_GAP_CYC);
                    next_st.state                         = FGR_MRS_WAIT;
                    next_st.busy                          = 1'b1;
                end
            end
            FGR_RFC_WAIT,
            FGR_MRS_WAIT: begin
                // Deselect only until the wait expires
                next_st.wait_cnt = st.wait_cnt - 1'b1;
                if (st.wait_cnt == fgr_pkg::CNT_W'(1)) begin
                    next_st.state = FGR_IDLE;
                    next_st.busy  = 1'b0;
                end
            end
            default: begin
                next_st.state = FGR_IDLE;
                next_st.busy  = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st.state     <= FGR_IDLE;
            st.mode      <= fgr_pkg::MODE_RESET;
            st.pend      <= 1'b0;
            st.pend_mode <= fgr_pkg::MODE_RESET;
            st.refi_cnt  <= fgr_pkg::CNT_W'(fgr_pkg::REFI_BASE_CYC);
            st.wait_cnt  <= fgr_pkg::CNT_ZERO;
            st.busy      <= 1'b0;
            st.ack       <= 1'b0;
            st.rej       <= 1'b0;
            st.issued    <= 1'b0;
            st.kind      <= fgr_pkg::FGR_KIND_1X;
            st.cs_n      <= 1'b1;
            st.ras_n     <= 1'b1;
            st.cas_n     <= 1'b1;
            st.we_n      <= 1'b1;
            st.bg0       <= 1'b0;
            st.ba        <= 2'h0;
            st.addr      <= 14'h0000;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus and status outputs from state, act_n held high
    assign cmd.cs_n               = st.cs_n;
    assign cmd.act_n              = 1'b1;
    assign cmd.ras_n              = st.ras_n;
    assign cmd.cas_n              = st.cas_n;
    assign cmd.we_n               = st.we_n;
    assign cmd.bg0                = st.bg0;
    assign cmd.ba                 = st.ba;
    assign cmd.addr               = st.addr;
    assign mode_ack               = st.ack;
    assign mode_reject            = st.rej;
    assign fine_refresh_rate_mode = st.mode;
    assign refresh_issued         = st.issued;
    assign refresh_kind           = st.kind;
    assign refresh_busy           = st.busy;

endmodule

// >>> hdl/fgr_pkg.sv
// Shared constants and types for the fine granularity refresh link
package fgr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Rate mode field codes
    localparam logic [2:0] MODE_FIXED_1X = 3'h0;
    localparam logic [2:0] MODE_FIXED_2X = 3'h1;
    localparam logic [2:0] MODE_FIXED_4X = 3'h2;
    localparam logic [2:0] MODE_DYN_1X2X = 3'h5;
    localparam logic [2:0] MODE_DYN_1X4X = 3'h6;
    localparam logic [2:0] MODE_RESET    = MODE_FIXED_1X;

    // Refresh kinds
    typedef enum logic [1:0] {
        FGR_KIND_1X,
        FGR_KIND_2X,
        FGR_KIND_4X
    } fgr_kind_t;

    ////////////////////////////////////////////////////////////////////////
    // Timing at the command clock
    localparam int CLK_PERIOD_NS   = 25;
    localparam int REFI_BASE_NS    = 7800;
    localparam int RFC1_NS         = 350;
    localparam int RFC2_NS         = 260;
    localparam int RFC4_NS         = 160;
    localparam int MRS_GAP_NS      = 600;
    // Longest interval rounds down, least cycle times round up
    localparam int REFI_BASE_CYC   = REFI_BASE_NS / CLK_PERIOD_NS;
    localparam int RFC1_CYC        = (RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC2_CYC        = (RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RFC4_CYC        = (RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MRS_GAP_CYC     = (MRS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W           = 9;
    localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;
    localparam logic [1:0] MR3_BANK = 2'h3;
    localparam int MODE_LSB        = 6;

    // Cycle time of one refresh kind
    function automatic logic [CNT_W-1:0] fgr_rfc_cyc(input fgr_kind_t kind);
        case (kind)
            FGR_KIND_2X: fgr_rfc_cyc = CNT_W'(RFC2_CYC);
            FGR_KIND_4X: fgr_rfc_cyc = CNT_W'(RFC4_CYC);
            default:     fgr_rfc_cyc = CNT_W'(RFC1_CYC);
        endcase
    endfunction

endpackage

// >>> hdl/fgr_cmd_if.sv
// Command bus between memory controller and DRAM refresh logic
interface fgr_cmd_if;
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bg0;
    logic [1:0]  ba;
    logic [13:0] addr;

    modport ctrl (output cs_n, output act_n, output ras_n, output cas_n,
                  output we_n, output bg0, output ba, output addr);
    modport dram (input cs_n, input act_n, input ras_n, input cas_n,
                  input we_n, input bg0, input ba, input addr);
endinterface

// >>> hdl/fgr_dram.sv
// DRAM end: rate mode decode and refresh execution
module fgr_dram (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Command bus
    fgr_cmd_if.dram         cmd,
    // Status
    output logic [2:0]      fine_refresh_rate_mode,
    output logic            dynamic_rate_select,
    output logic            refresh_busy,
    output logic            refresh_start,
    output logic [1:0]      refresh_kind,
    output logic            cmd_error
);

    typedef struct packed {
        logic [2:0]              mode;
        logic [fgr_pkg::CNT_W-1:0] busy_cnt;
        logic                    busy;
        logic                    start;
        fgr_pkg::fgr_kind_t      kind;
        logic                    err;
    } fgr_dram_st_t;

    fgr_dram_st_t st;
    fgr_dram_st_t next_st;
    logic         is_ref;
    logic         is_mrs;
    logic         is_des;
    logic [2:0]   wr_mode;
    fgr_pkg::fgr_kind_t ref_kind;

    ////////////////////////////////////////////////////////////////////////
    // Command decode
    assign is_des  = cmd.cs_n;
    assign is_ref  = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
    assign is_mrs  = !cmd.cs_n && cmd.act_n && !cmd.ras_n && !cmd.cas_n && !cmd.we_n
                     && (cmd.ba == fgr_pkg::MR3_BANK);
    assign wr_mode = cmd.addr[fgr_pkg::MODE_LSB +: 3];

    // Kind of an incoming refresh from mode and bank-group bit
    always_comb begin
        case (st.mode)
            fgr_pkg::MODE_FIXED_2X: ref_kind = fgr_pkg::FGR_KIND_2X;
            fgr_pkg::MODE_FIXED_4X: ref_kind = fgr_pkg::FGR_KIND_4X;
            fgr_pkg::MODE_DYN_1X2X: ref_kind = cmd.bg0 ? fgr_pkg::FGR_KIND_2X
                                                       : fgr_pkg::FGR_KIND_1X;
            fgr_pkg::MODE_DYN_1X4X: ref_kind = cmd.bg0 ? fgr_pkg::FGR_KIND_4X
                                                       : fgr_pkg::FGR_KIND_1X;
            default:                ref_kind = fgr_pkg::FGR_KIND_1X;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st       = st;
        next_st.start = 1'b0;
        next_st.err   = 1'b0;
        if (st.busy) begin
            next_st.busy_cnt = st.busy_cnt - 1'b1;
            if (st.busy_cnt == fgr_pkg::CNT_W'(1)) begin
                next_st.busy = 1'b0;
            end
            if (!is_des) begin
                next_st.err = 1'b1; // Only deselect allowed while refreshing
            end
        end else if (is_ref) begin
            next_st.busy     = 1'b1;
            next_st.start    = 1'b1;
            next_st.kind     = ref_kind;
            next_st.busy_cnt = fgr_pkg::fgr_rfc_cyc(ref_kind);
        end else if (is_mrs) begin
            case (wr_mode)
                fgr_pkg::MODE_FIXED_1X,
                fgr_pkg::MODE_FIXED_2X,
                fgr_pkg::MODE_FIXED_4X,
                fgr_pkg::MODE_DYN_1X2X,
                fgr_pkg::MODE_DYN_1X4X: next_st.mode = wr_mode;
                default:                next_st.err  = 1'b1; // Reserved code kept out
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st.mode     <= fgr_pkg::MODE_RESET;
            st.busy_cnt <= fgr_pkg::CNT_ZERO;
            st.busy     <= 1'b0;
            st.start    <= 1'b0;
            st.kind     <= fgr_pkg::FGR_KIND_1X;
            st.err      <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign fine_refresh_rate_mode = st.mode;
    assign dynamic_rate_select    = st.mode[2];
    assign refresh_busy           = st.busy;
    assign refresh_start          = st.start;
    assign refresh_kind           = st.kind;
    assign cmd_error              = st.err;

endmodule

// >>> tb/fgr_link_sva.sv
// Checker for the command bus and the DRAM end's refresh status
module fgr_link_sva (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       sys_rst,
    // Command bus
    input wire logic       cs_n,
    input wire logic       act_n,
    input wire logic       ras_n,
    input wire logic       cas_n,
    input wire logic       we_n,
    input wire logic       bg0,
    input wire logic [1:0] ba,
    input wire logic [13:0] addr,
    // DRAM status
    input wire logic [2:0] fine_refresh_rate_mode,
    input wire logic       dynamic_rate_select,
    input wire logic       refresh_busy,
    input wire logic       refresh_start,
    input wire logic [1:0] refresh_kind,
    input wire logic       cmd_error
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Command shapes
    sequence ref_cmd;
        !cs_n && act_n && !ras_n && !cas_n && we_n;
    endsequence
    sequence mrs_dyn;
        !cs_n && act_n && !ras_n && !cas_n && !we_n && ba == 2'h3
            && (addr[8:6] == 3'h5 || addr[8:6] == 3'h6);
    endsequence

    // Length of the current busy run
    logic [8:0] busy_run;
    always_ff @(posedge core_clk) begin
        if (sys_rst || !refresh_busy) begin
            busy_run <= 9'h000;
        end else begin
            busy_run <= busy_run + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Properties
    chk_ref_starts_busy: assert property (ref_cmd |=> refresh_start && refresh_busy)
        else $error("refresh command did not start a refresh");
    chk_fixed_rate_kind: assert property (
        ref_cmd ##0 !fine_refresh_rate_mode[2]
            |=> refresh_kind == $past(fine_refresh_rate_mode[1:0]))
        else $error("fixed mode refresh of wrong kind");
    chk_dyn_double_kind: assert property (
        ref_cmd ##0 fine_refresh_rate_mode == 3'h5
            |=> refresh_kind == ($past(bg0) ? 2'h1 : 2'h0))
        else $error("dynamic 1x/2x refresh of wrong kind");
    chk_dyn_quad_kind: assert property (
        ref_cmd ##0 fine_refresh_rate_mode == 3'h6
            |=> refresh_kind == ($past(bg0) ? 2'h2 : 2'h0))
        else $error("dynamic 1x/4x refresh of wrong kind");
    chk_dyn_mode_set: assert property (
        mrs_dyn |=> dynamic_rate_select && fine_refresh_rate_mode == $past(addr[8:6]))
        else $error("dynamic mode not taken from mode set");
    chk_rfc_length: assert property (
        $fell(refresh_busy) |-> busy_run == (refresh_kind == 2'h2 ? fgr_pkg::RFC4_CYC :
            refresh_kind == 2'h1 ? fgr_pkg::RFC2_CYC : fgr_pkg::RFC1_CYC))
        else $error("refresh cycle time wrong");
    chk_des_in_refresh: assert property (refresh_busy |-> cs_n)
        else $error("command during refresh");
    chk_no_cmd_error: assert property (!cmd_error)
        else $error("dram flagged a command error");
endmodule

// >>> tb/fine_granularity_refresh_bench.sv
// Bench joining controller and DRAM ends over the command bus
module fine_granularity_refresh_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // Stimulus
    logic       core_clk, sys_rst, mode_req_valid, temperature_scaled_refresh;
    logic       fast_refresh_pref;
    logic [2:0] mode_req;
    logic [1:0] temp_band;
    // Controller status
    logic       mode_ack, mode_reject, refresh_issued, c_busy;
    logic [2:0] c_mode;
    logic [1:0] c_kind;
    // DRAM status
    logic       d_dyn, d_busy, d_start, d_err;
    logic [2:0] d_mode;
    logic [1:0] d_kind;
    // Bookkeeping
    int         error_cnt, n_compared, cyc, last_iss, skip, seed, exp_g;
    logic [1:0] prev_kind;
    logic       d_pend;
    logic [2:0] exp_mode;

    fgr_cmd_if fgr_cmd_if_inst ();
    fgr_ctrl fgr_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .cmd(fgr_cmd_if_inst),
        .mode_req_valid(mode_req_valid), .mode_req(mode_req),
        .temperature_scaled_refresh(temperature_scaled_refresh), .temp_band(temp_band),
        .fast_refresh_pref(fast_refresh_pref), .mode_ack(mode_ack), .mode_reject(mode_reject),
        .fine_refresh_rate_mode(c_mode), .refresh_issued(refresh_issued),
        .refresh_kind(c_kind), .refresh_busy(c_busy));
    fgr_dram fgr_dram_inst (.core_clk(core_clk), .sys_rst(sys_rst), .cmd(fgr_cmd_if_inst),
        .fine_refresh_rate_mode(d_mode), .dynamic_rate_select(d_dyn), .refresh_busy(d_busy),
        .refresh_start(d_start), .refresh_kind(d_kind), .cmd_error(d_err));
    fgr_link_sva fgr_link_sva_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .cs_n(fgr_cmd_if_inst.cs_n), .act_n(fgr_cmd_if_inst.act_n),
        .ras_n(fgr_cmd_if_inst.ras_n), .cas_n(fgr_cmd_if_inst.cas_n),
        .we_n(fgr_cmd_if_inst.we_n), .bg0(fgr_cmd_if_inst.bg0), .ba(fgr_cmd_if_inst.ba),
        .addr(fgr_cmd_if_inst.addr), .fine_refresh_rate_mode(d_mode),
        .dynamic_rate_select(d_dyn), .refresh_busy(d_busy), .refresh_start(d_start),
        .refresh_kind(d_kind), .cmd_error(d_err));

    ////////////////////////////////////////////////////////////////////////
    // Compare, expectation and closing helpers
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] exp_kind(input logic [2:0] m, input logic p);
        case (m)
            3'h1: exp_kind = 2'h1;
            3'h2: exp_kind = 2'h2;
            3'h5: exp_kind = p ? 2'h1 : 2'h0;
            3'h6: exp_kind = p ? 2'h2 : 2'h0;
            default: exp_kind = 2'h0;
        endcase
    endfunction
    function automatic int exp_gap(input logic [1:0] k, input logic [1:0] b);
        exp_gap = (fgr_pkg::REFI_BASE_CYC >> (int'(k) + int'(b))) + 1;
    endfunction
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Watch every issued refresh on the wire
    always @(negedge core_clk) begin
        if (!sys_rst) begin
            cyc++;
            // DRAM end takes each refresh one cycle after it leaves the controller
            if (d_pend) begin
                cmp_val(d_kind, prev_kind);
                cmp_flag(d_start, 1'b1);
            end
            d_pend = (refresh_issued === 1'b1);
            if (refresh_issued === 1'b1) begin
                cmp_val({fgr_cmd_if_inst.cs_n, fgr_cmd_if_inst.act_n, fgr_cmd_if_inst.ras_n,
                         fgr_cmd_if_inst.cas_n, fgr_cmd_if_inst.we_n}, 32'h9);
                cmp_val(c_kind, exp_kind(exp_mode, fast_refresh_pref));
                if (exp_mode[2]) cmp_flag(fgr_cmd_if_inst.bg0, c_kind != 2'h0);
                exp_g = exp_gap(prev_kind, temp_band);
                if (skip == 0) begin
                    cmp_val(cyc - last_iss, exp_g);
                end else begin
                    skip--;
                end
                last_iss = cyc;
                prev_kind = exp_kind(exp_mode, fast_refresh_pref);
            end
            if (cyc > 60000) begin
                error_cnt++;
                end_of_test();
            end
        end
    end

    // One mode request during a refresh, new band and preference, then four refreshes
    task automatic run_phase(input logic [2:0] code, input logic tsr);
        int   n;
        logic ok;
        ok = (code inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}) && (!tsr || code == 3'h0);
        n = 0;
        do begin @(negedge core_clk); n++; end while (c_busy !== 1'b1 && n < 1000);
        cmp_flag(c_busy, 1'b1);
        @(posedge core_clk);
        mode_req <= code;
        mode_req_valid <= 1'b1;
        temperature_scaled_refresh <= tsr;
        temp_band <= 2'($random(seed));
        fast_refresh_pref <= 1'($random(seed));
        skip = 1;
        @(posedge core_clk);
        mode_req_valid <= 1'b0;
        n = 0;
        do begin @(negedge core_clk); n++; end
        while (mode_ack !== 1'b1 && mode_reject !== 1'b1 && n < 400);
        cmp_flag(mode_ack, ok);
        cmp_flag(mode_reject, !ok);
        if (ok) begin
            exp_mode = code;
            cmp_val(c_mode, code);
            @(negedge core_clk);
            cmp_val(d_mode, code);
            cmp_flag(d_dyn, code[2]);
        end else begin
            cmp_val(c_mode, exp_mode);
            cmp_val(d_mode, exp_mode);
        end
        repeat (4) begin
            n = 0;
            do begin @(negedge core_clk); n++; end while (refresh_issued !== 1'b1 && n < 400);
            cmp_flag(refresh_issued, 1'b1);
        end
    endtask

    // Every code, scaling with two refusals and fixed 1x accepted, then random codes
    initial begin
        seed = 32'h2bf6;
        {error_cnt, n_compared, cyc, last_iss} = '0;
        skip = 1;
        exp_mode = 3'h0;
        prev_kind = 2'h0;
        d_pend = 1'b0;
        {mode_req_valid, temperature_scaled_refresh, fast_refresh_pref} = 3'h0;
        mode_req = 3'h0;
        temp_band = 2'h0;
        sys_rst = 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int c = 0; c < 8; c++) run_phase(3'(c), 1'b0);
        run_phase(3'h5, 1'b1);
        run_phase(3'h1, 1'b1);
        run_phase(3'h0, 1'b1);
        repeat (6) run_phase(3'($unsigned($random(seed)) % 8), 1'b0);
        end_of_test();
    end
endmodule
